// file: design/gdpc_pkg.sv
// Package for the GPIO direction and polarity configuration block.
// Assumes a byte-wide configuration port with index and data accesses.
package gdpc_pkg;
  // ----------------------------------------------------------------
  // Register indexes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DIR_G1 = 8'h31;
  localparam logic [7:0] IDX_POL_G1 = 8'h32;
  localparam logic [7:0] IDX_DIR_G2 = 8'h33;
  localparam logic [7:0] IDX_POL_G2 = 8'h34;
  localparam logic [7:0] IDX_OBT = 8'h39;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] DIR_G2_WMASK = 8'hDF;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int G1_PINS = 8;
  localparam int G2_PINS = 5;
  localparam int ALT_G2_BIT = 6;
  localparam int ALT_SMI_BIT = 7;
  localparam int PME_POL_BIT = 5;
  localparam int IRQ1_SEL_BIT = 6;
  localparam int IRQ2_SEL_BIT = 7;
  localparam int SMI_PIN = 2;
  localparam int IRQ1_PIN = 3;
  localparam int IRQ2_PIN = 4;
  localparam int ALT_PIN = 3;
  localparam int OBT_SMI_BIT = 0;
  localparam int OBT_PME_BIT = 7;

  typedef struct packed {
    logic [7:0] dir_g1;
    logic [7:0] pol_g1;
    logic [7:0] dir_g2;
    logic [7:0] pol_g2;
  } gdpc_regs_t;
endpackage

// file: design/gdpc_top.sv
// GPIO direction and polarity configuration with alternate-function routing.
// Assumes a configuration-state flag and byte index and data strobes from the host port.
// Summary of operation
// - Access only in config state with matching index.
// - Group1 direction bits: 0 input, 1 output.
// - Group1 polarity bits: 0 normal, 1 inverted.
// - Group2 direction bits 0-4.
// - Group2 direction bit 5 reads zero.
// - Bits 6,7 select alternate pin functions.
// - Alternate input still follows polarity bit.
// - SMI output active low when non-inverted.
// - Group2 polarity bits 0-4.
// - Power event polarity, non-inverted active low.
// - Bits 6,7 route pins to IRQ inputs.
// - All configuration registers clear on standby reset.
// - Output type register picks open drain.
//
// Register access is two-step: an index write selects one of the four
// registers, then data strokes read or write it. Strokes outside the
// configuration state are dropped, so a stray host cycle in normal
// operation can never reconfigure a pin.
//
// Every output is registered. Pin levels pass a three-stage synchroniser
// and a stability stage before they reach the value outputs, so a pin
// change shows four edges after it is first sampled.
`timescale 1ns/100ps
module gdpc_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_cfg_state,
  input wire logic i_idx_wr,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_obt,
  input wire logic [7:0] i_g1_pin_in,
  input wire logic [4:0] i_g2_pin_in,
  input wire logic [7:0] i_g1_out_val,
  input wire logic [4:0] i_g2_out_val,
  input wire logic i_smi_req,
  input wire logic i_pme_req,
  output logic [7:0] o_g1_pin_out,
  output logic [7:0] o_g1_pin_oe_b,
  output logic [4:0] o_g2_pin_out,
  output logic [4:0] o_g2_pin_oe_b,
  output logic [7:0] o_g1_in_val,
  output logic [4:0] o_g2_in_val,
  output logic o_alt_in,
  output logic o_aux_irq_input_1,
  output logic o_aux_irq_input_2,
  output logic o_power_event_out,
  output logic o_power_event_oe_b
);
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  gdpc_pkg::gdpc_regs_t regs_r, regs_nxt;
  logic [7:0] index_r, index_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // ----------------------------------------------------------------
  // Register decode helpers
  // ----------------------------------------------------------------
  // Both the write and the read path decode the index here, so the two
  // can never disagree about which index owns which register.
  function automatic gdpc_pkg::gdpc_regs_t write_reg(
    input gdpc_pkg::gdpc_regs_t cur,
    input logic [7:0] idx,
    input logic [7:0] data
  );
    gdpc_pkg::gdpc_regs_t upd;
    upd = cur;
    unique case (idx)
      gdpc_pkg::IDX_DIR_G1: upd.dir_g1 = data;
      gdpc_pkg::IDX_POL_G1: upd.pol_g1 = data;
      gdpc_pkg::IDX_DIR_G2: upd.dir_g2 = data & gdpc_pkg::DIR_G2_WMASK;
      gdpc_pkg::IDX_POL_G2: upd.pol_g2 = data;
      default: ;
    endcase
    return upd;
  endfunction

  // Indexes that belong to other blocks read as zero here; the host port
  // merges the answers, so returning anything else would corrupt them.
  function automatic logic [7:0] read_reg(
    input gdpc_pkg::gdpc_regs_t cur,
    input logic [7:0] idx
  );
    logic [7:0] val;
    val = gdpc_pkg::RST_VAL;
    unique case (idx)
      gdpc_pkg::IDX_DIR_G1: val = cur.dir_g1;
      gdpc_pkg::IDX_POL_G1: val = cur.pol_g1;
      gdpc_pkg::IDX_DIR_G2: val = cur.dir_g2 & gdpc_pkg::DIR_G2_WMASK;
      gdpc_pkg::IDX_POL_G2: val = cur.pol_g2;
      default: val = gdpc_pkg::RST_VAL;
    endcase
    return val;
  endfunction

  // A data stroke uses the index held before this edge, so an index
  // write and a data stroke in the same cycle do not interact.
  always_comb begin
    regs_nxt = regs_r;
    index_nxt = index_r;
    rdata_nxt = rdata_r;
    if (i_cfg_state && i_idx_wr) begin
      index_nxt = i_wdata;
    end
    if (i_cfg_state && i_data_wr) begin
      regs_nxt = write_reg(regs_r, index_r, i_wdata);
    end
    if (i_cfg_state && i_data_rd) begin
      rdata_nxt = read_reg(regs_r, index_r);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      regs_r <= '0;
      index_r <= 8'h00;
      rdata_r <= 8'h00;
    end else if (i_ce) begin
      regs_r <= regs_nxt;
      index_r <= index_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change is taken once stages two and three agree.
  // The stability stage costs one edge of latency but keeps a pin that
  // is caught mid-transition from producing a one-cycle glitch.
  localparam int N_PINS = gdpc_pkg::G1_PINS + gdpc_pkg::G2_PINS;

  // The vectors below are laid out for the two fixed pin groups.
  if (N_PINS != 13) begin : g_pin_count_check
    $error("pin group widths do not match the synchroniser");
  end

  logic [12:0] s1_r, s2_r, s3_r, stab_r;
  logic [12:0] s1_nxt, s2_nxt, s3_nxt, stab_nxt;

  always_comb begin
    s1_nxt = {i_g2_pin_in, i_g1_pin_in};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    stab_nxt = stab_r;
    for (int k = 0; k < 13; k++) begin
      if (s2_r[k] == s3_r[k]) begin
        stab_nxt[k] = s3_r[k];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      s1_r <= 13'h0000;
      s2_r <= 13'h0000;
      s3_r <= 13'h0000;
      stab_r <= 13'h0000;
    end else if (i_ce) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      stab_r <= stab_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and routing
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] g1_out;
    logic [7:0] g1_oe_b;
    logic [4:0] g2_out;
    logic [4:0] g2_oe_b;
    logic [7:0] g1_in;
    logic [4:0] g2_in;
    logic alt_in;
    logic irq1;
    logic irq2;
    logic pme_out;
    logic pme_oe_b;
  } gdpc_pins_t;
  gdpc_pins_t pins_r, pins_nxt;
  logic smi_lvl;
  logic pme_lvl;

  always_comb begin
    pins_nxt.g1_in = stab_r[7:0] ^ regs_r.pol_g1;
    pins_nxt.g2_in = stab_r[12:8] ^ regs_r.pol_g2[4:0];
    pins_nxt.g1_out = i_g1_out_val ^ regs_r.pol_g1;
    pins_nxt.g2_out = i_g2_out_val ^ regs_r.pol_g2[4:0];
    pins_nxt.g1_oe_b = ~regs_r.dir_g1;
    pins_nxt.g2_oe_b = ~regs_r.dir_g2[4:0];
    // Pins steered to IRQ inputs are treated as inputs whatever the direction bit.
    pins_nxt.irq1 = 1'b0;
    pins_nxt.irq2 = 1'b0;
    if (regs_r.pol_g2[gdpc_pkg::IRQ1_SEL_BIT]) begin
      pins_nxt.irq1 = stab_r[gdpc_pkg::IRQ1_PIN] ^ regs_r.pol_g1[gdpc_pkg::IRQ1_PIN];
      pins_nxt.g1_oe_b[gdpc_pkg::IRQ1_PIN] = 1'b1;
    end
    if (regs_r.pol_g2[gdpc_pkg::IRQ2_SEL_BIT]) begin
      pins_nxt.irq2 = stab_r[gdpc_pkg::IRQ2_PIN] ^ regs_r.pol_g1[gdpc_pkg::IRQ2_PIN];
      pins_nxt.g1_oe_b[gdpc_pkg::IRQ2_PIN] = 1'b1;
    end
    pins_nxt.alt_in = 1'b0;
    if (regs_r.dir_g2[gdpc_pkg::ALT_G2_BIT]) begin
      pins_nxt.alt_in = pins_nxt.g2_in[gdpc_pkg::ALT_PIN];
    end
    // Non-inverted gives an active-low request level on the pin.
    smi_lvl = ~i_smi_req ^ regs_r.pol_g1[gdpc_pkg::SMI_PIN];
    if (regs_r.dir_g2[gdpc_pkg::ALT_SMI_BIT]) begin
      pins_nxt.g1_out[gdpc_pkg::SMI_PIN] = smi_lvl;
      pins_nxt.g1_oe_b[gdpc_pkg::SMI_PIN] = 1'b0;
      if (i_obt[gdpc_pkg::OBT_SMI_BIT] && smi_lvl) begin
        pins_nxt.g1_oe_b[gdpc_pkg::SMI_PIN] = 1'b1;
      end
    end
    pme_lvl = ~i_pme_req ^ regs_r.pol_g2[gdpc_pkg::PME_POL_BIT];
    pins_nxt.pme_out = pme_lvl;
    pins_nxt.pme_oe_b = i_obt[gdpc_pkg::OBT_PME_BIT] & pme_lvl;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pins_r <= '0;
      pins_r.g1_oe_b <= 8'hFF;
      pins_r.g2_oe_b <= 5'h1F;
      pins_r.pme_out <= 1'b1;
    end else if (i_ce) begin
      pins_r <= pins_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_g1_pin_out = pins_r.g1_out;
  assign o_g1_pin_oe_b = pins_r.g1_oe_b;
  assign o_g2_pin_out = pins_r.g2_out;
  assign o_g2_pin_oe_b = pins_r.g2_oe_b;
  assign o_g1_in_val = pins_r.g1_in;
  assign o_g2_in_val = pins_r.g2_in;
  assign o_alt_in = pins_r.alt_in;
  assign o_aux_irq_input_1 = pins_r.irq1;
  assign o_aux_irq_input_2 = pins_r.irq2;
  assign o_power_event_out = pins_r.pme_out;
  assign o_power_event_oe_b = pins_r.pme_oe_b;
endmodule

// file: tb/gdpc_top_monitor.sv
// Checker for gdpc_top, bound to every instance.
// Assumes the top's own port names.
`timescale 1ns/100ps
module gdpc_top_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_cfg_state,
  input wire logic i_idx_wr,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_obt,
  input wire logic i_pme_req,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_g1_pin_oe_b,
  input wire logic o_alt_in,
  input wire logic o_aux_irq_input_1,
  input wire logic o_aux_irq_input_2,
  input wire logic o_power_event_out,
  input wire logic o_power_event_oe_b
);
  logic go;
  logic [7:0] idx_r;
  logic [7:0] d2_r;
  logic [7:0] p2_r;
  assign go = i_ce && i_cfg_state;
  // Shadows of the index and group two registers, so routing checks know the mode.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      idx_r <= 8'h00;
      d2_r <= 8'h00;
      p2_r <= 8'h00;
    end else begin
      if (go && i_idx_wr) idx_r <= i_wdata;
      if (go && i_data_wr && idx_r == 8'h33) d2_r <= i_wdata;
      if (go && i_data_wr && idx_r == 8'h34) p2_r <= i_wdata;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  rd_hold_a: assert property (i_ce && !i_cfg_state |=> $stable(o_rdata))
    else $error("read data moved outside config state");
  rsv_bit_a: assert property (go && i_data_rd && idx_r == 8'h33 |=> !o_rdata[5])
    else $error("reserved bit read as one");
  rst_oe_a: assert property ($rose(i_rst_b) |-> o_g1_pin_oe_b == 8'hFF)
    else $error("pin driven after reset");
  obt_pp_a: assert property ($past(i_rst_b) && $past(i_ce) && !$past(i_obt[7])
    |-> !o_power_event_oe_b)
    else $error("push-pull event pin not driven");
  pme_pol_a: assert property ($past(i_ce) && $past(i_rst_b)
    |-> o_power_event_out == ($past(!i_pme_req) ^ $past(p2_r[5])))
    else $error("event output level wrong");
  irq1_off_a: assert property ((i_ce && !p2_r[6])[*4] |=> !o_aux_irq_input_1)
    else $error("irq one active while unrouted");
  irq2_off_a: assert property ((i_ce && !p2_r[7])[*4] |=> !o_aux_irq_input_2)
    else $error("irq two active while unrouted");
  alt_off_a: assert property ((i_ce && !d2_r[6])[*4] |=> !o_alt_in)
    else $error("alternate input active while unselected");
  cover property (go && i_data_wr && idx_r == 8'h34 && i_wdata[6]);
  cover property (go && i_data_rd && idx_r == 8'h33);
  cover property (i_ce && !i_cfg_state && i_data_wr);
endmodule
bind gdpc_top gdpc_top_monitor u_gdpc_top_monitor (.*);

// file: tb/gdpc_pin_model.sv
// External pin drivers facing the block.
// Assumes no pulls: an undriven wire takes the external level.
`timescale 1ns/100ps
module gdpc_pin_model (
  input wire logic [7:0] i_g1_out,
  input wire logic [7:0] i_g1_oe_b,
  input wire logic [7:0] i_g1_ext,
  input wire logic [4:0] i_g2_out,
  input wire logic [4:0] i_g2_oe_b,
  input wire logic [4:0] i_g2_ext,
  output logic [7:0] o_g1_pin,
  output logic [4:0] o_g2_pin
);
  assign o_g1_pin = (i_g1_out & ~i_g1_oe_b) | (i_g1_ext & i_g1_oe_b);
  assign o_g2_pin = (i_g2_out & ~i_g2_oe_b) | (i_g2_ext & i_g2_oe_b);
endmodule

// file: tb/gdpc_top_bench.sv
// Bench for gdpc_top: register access, pin direction, polarity and routing.
// Assumes the pin model on the pin side and the bound checker.
`timescale 1ns/100ps
module gdpc_top_bench;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_cfg_state = 1'b1;
  logic i_idx_wr = 1'b0, i_data_wr = 1'b0, i_data_rd = 1'b0, i_smi_req = 1'b0, i_pme_req = 1'b0;
  logic [7:0] i_wdata = 8'h00, i_obt = 8'h00, i_g1_out_val = 8'hA5, g1_ext = 8'h3C;
  logic [4:0] i_g2_out_val = 5'h05, g2_ext = 5'h00, i_g2_pin_in, o_g2_pin_out;
  logic [4:0] o_g2_pin_oe_b, o_g2_in_val;
  logic [7:0] i_g1_pin_in, o_rdata, o_g1_pin_out, o_g1_pin_oe_b, o_g1_in_val;
  logic o_alt_in, o_aux_irq_input_1, o_aux_irq_input_2, o_power_event_out, o_power_event_oe_b;
  int n_errors = 0, n_compared = 0;
  gdpc_top u_gdpc_top (.*);
  gdpc_pin_model u_gdpc_pin_model (.i_g1_out(o_g1_pin_out), .i_g1_oe_b(o_g1_pin_oe_b),
    .i_g1_ext(g1_ext), .i_g2_out(o_g2_pin_out), .i_g2_oe_b(o_g2_pin_oe_b),
    .i_g2_ext(g2_ext), .o_g1_pin(i_g1_pin_in), .o_g2_pin(i_g2_pin_in));
  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  task automatic acc(input logic [7:0] idx, input logic [7:0] d, input logic wr);
    @(negedge i_sys_clk) i_idx_wr = 1'b1;
    i_wdata = idx;
    @(negedge i_sys_clk) i_idx_wr = 1'b0;
    i_data_wr = wr;
    i_data_rd = !wr;
    i_wdata = d;
    @(negedge i_sys_clk) i_data_wr = 1'b0;
    i_data_rd = 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    acc(idx, 8'h00, 1'b0);
    chk(o_rdata, exp);
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdc(8'h31 + 8'(i), 8'h00);
      acc(8'h31 + 8'(i), 8'hFF, 1'b1);
      rdc(8'h31 + 8'(i), (i == 2) ? 8'hDF : 8'hFF);
    end
    i_cfg_state = 1'b0;
    acc(8'h31, 8'h00, 1'b1);
    i_cfg_state = 1'b1;
    rdc(8'h31, 8'hFF);
    rdc(8'h35, 8'h00);
    $display("register test done");
    acc(8'h33, 8'h1F, 1'b1);
    acc(8'h34, 8'h1F, 1'b1);
    acc(8'h32, 8'h00, 1'b1);
    repeat (2) @(negedge i_sys_clk);
    chk(o_g1_pin_out, 8'hA5);
    chk({o_g1_pin_oe_b[7:3], o_g2_pin_oe_b[2:0]}, 8'h00);
    chk({3'h0, o_g2_pin_out}, 8'h1A);
    acc(8'h32, 8'hFF, 1'b1);
    repeat (2) @(negedge i_sys_clk);
    chk(o_g1_pin_out, 8'h5A);
    acc(8'h31, 8'h00, 1'b1);
    repeat (6) @(negedge i_sys_clk);
    chk(o_g1_pin_oe_b, 8'hFF);
    chk(o_g1_in_val, 8'hC3);
    chk({3'h0, o_g2_in_val}, 8'h05);
    $display("pin test done");
    acc(8'h31, 8'h04, 1'b1);
    acc(8'h32, 8'h00, 1'b1);
    acc(8'h33, 8'h80, 1'b1);
    acc(8'h34, 8'h00, 1'b1);
    i_smi_req = 1'b1;
    i_pme_req = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    chk({5'h00, o_g1_pin_out[2], o_g1_pin_oe_b[2], o_power_event_out}, 8'h00);
    i_smi_req = 1'b0;
    i_pme_req = 1'b0;
    i_obt = 8'h81;
    repeat (2) @(negedge i_sys_clk);
    chk({4'h0, o_g1_pin_out[2], o_g1_pin_oe_b[2], o_power_event_out, o_power_event_oe_b},
      8'h0F);
    i_obt = 8'h00;
    acc(8'h34, 8'h20, 1'b1);
    repeat (2) @(negedge i_sys_clk);
    chk({6'h00, o_power_event_out, o_power_event_oe_b}, 8'h00);
    acc(8'h33, 8'h00, 1'b1);
    acc(8'h34, 8'hC0, 1'b1);
    g1_ext = 8'h08;
    repeat (6) @(negedge i_sys_clk);
    chk({5'h00, o_aux_irq_input_1, o_aux_irq_input_2, o_g1_pin_oe_b[3]}, 8'h05);
    g1_ext = 8'h10;
    repeat (6) @(negedge i_sys_clk);
    chk({5'h00, o_aux_irq_input_1, o_aux_irq_input_2, o_g1_pin_oe_b[4]}, 8'h03);
    acc(8'h33, 8'h40, 1'b1);
    acc(8'h34, 8'h08, 1'b1);
    repeat (6) @(negedge i_sys_clk);
    chk({7'h00, o_alt_in}, 8'h01);
    $display("routing test done");
    test_done;
  end
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule
